// >>> core/sacr_pkg.sv
// package for the sense amplifier configuration register bank
// assumes a single 100 MHz clock domain and an avalon-mm slave bus
package sacr_pkg;
  // ***********************
  // register word offsets
  // ***********************
  localparam int REG_INDEX_W = 3;
  localparam logic [REG_INDEX_W-1:0] SENSE_AMP_CONTROL_IDX = 3'h6;
  localparam logic [REG_INDEX_W-1:0] DRIVER_CONFIGURATION_IDX = 3'h7;
  localparam logic [REG_INDEX_W-1:0] IRQ_STATUS_IDX = 3'h2;
  localparam logic [REG_INDEX_W-1:0] IRQ_MASK_IDX = 3'h3;
  localparam logic [REG_INDEX_W-1:0] FAULT_CTRL_IDX = 3'h4;
  localparam int ADDR_W = 5;
  // ***********************
  // field positions
  // ***********************
  localparam int AMP_INPUT_SELECT_BIT = 10;
  localparam int REF_HALVE_BIT = 9;
  localparam int LOWSIDE_OCP_REF_SELECT_BIT = 8;
  localparam int AMP_GAIN_SELECT_LSB = 6;
  localparam int SHUNT_OCP_DISABLE_BIT = 5;
  localparam int OFFSET_CAL_CHAN_A_BIT = 4;
  localparam int OFFSET_CAL_CHAN_B_BIT = 3;
  localparam int OFFSET_CAL_CHAN_C_BIT = 2;
  localparam int SHUNT_OCP_THRESHOLD_LSB = 0;
  localparam int AUTO_CAL_BIT = 0;
  localparam int REG_W = 11;
  // ***********************
  // reset values
  // ***********************
  localparam logic [REG_W-1:0] SENSE_AMP_CONTROL_RST = 11'h283;
  localparam logic [REG_W-1:0] DRIVER_CONFIGURATION_RST = 11'h000;
  // interrupt event bit positions
  localparam int EVT_SHUNT_OC = 0;
  localparam int EVT_DS_OC = 1;
  localparam int EVT_W = 2;
  // gain codes
  typedef enum logic [1:0] {
    SACR_GAIN_5 = 2'h0,
    SACR_GAIN_10 = 2'h1,
    SACR_GAIN_20 = 2'h2,
    SACR_GAIN_40 = 2'h3
  } sacr_gain_e;
  // overcurrent threshold codes
  typedef enum logic [1:0] {
    SACR_OCP_0P25 = 2'h0,
    SACR_OCP_0P50 = 2'h1,
    SACR_OCP_0P75 = 2'h2,
    SACR_OCP_1P00 = 2'h3
  } sacr_ocp_lvl_e;
endpackage

// >>> core/sacr_regs.sv
// sense amplifier configuration register bank with avalon-mm slave
// assumes synchronous comparator inputs and an external pull-up on the fault pin
// Overview of operation
// [R1] amp_input_select clear routes the amp positive input from the shunt positive pin, set from the switch node.
// [R2] writing one to amp_input_select also forces lowside_ocp_ref_select to one.
// [R3] the reference halving bit selects full reference when clear and half reference when set, resetting to one.
// [R4] lowside_ocp_ref_select picks switch node to shunt positive when clear, to shunt negative when set.
// [R5] amp_gain_select codes 00/01/10/11 give gains 5/10/20/40, resetting to code 10 (gain 20).
// [R6] shunt_ocp_disable clear keeps the shunt overcurrent fault active, set suppresses it fully.
// [R7] offset_cal_chan_a/b/c on bits 4/3/2 short that amplifier's inputs when set.
// [R8] shunt_ocp_threshold codes 00/01/10/11 give 0.25/0.5/0.75/1 V, resetting to 11.
// [R9] bit 0 of the driver configuration picks manual calibration when clear and automatic when set.
// [R10] the fault output is open drain and only ever drives low.
// [R11] the ten reserved driver configuration bits reset to zero and are freely read and written.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps
module sacr_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [sacr_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic [1:0] o_response,
  input wire logic i_shunt_overcurrent_trip,
  input wire logic i_drain_source_overcurrent_trip,
  output logic o_amp_input_select,
  output logic o_ref_halve,
  output logic o_lowside_ocp_ref_select,
  output logic [1:0] o_amp_gain_select,
  output logic o_shunt_ocp_enabled,
  output logic [1:0] o_shunt_ocp_threshold,
  output logic [2:0] o_offset_cal_short,
  output logic o_auto_cal,
  output logic o_fault_out_n_o,
  output logic o_fault_out_n_oe_n,
  output logic o_irq
);
  // ***********************
  // bus handshake
  // ***********************
  // one wait cycle: the request is acknowledged in the cycle after it is seen
  logic ack_ff;
  logic req;
  logic [sacr_pkg::REG_INDEX_W-1:0] idx;
  logic mapped;
  logic wr_en;
  logic [sacr_pkg::REG_W-1:0] wmask;

  function automatic logic [sacr_pkg::REG_W-1:0] merge(input logic [sacr_pkg::REG_W-1:0] old,
                                                        input logic [31:0] wd, input logic [3:0] be);
    logic [sacr_pkg::REG_W-1:0] m;
    m = {{3{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd[sacr_pkg::REG_W-1:0] & m);
  endfunction

  assign req = (i_read | i_write) & ~ack_ff;
  assign idx = i_address[sacr_pkg::REG_INDEX_W+1:2];
  assign mapped = (i_address[1:0] == 2'h0) &&
                  ((idx == sacr_pkg::SENSE_AMP_CONTROL_IDX) || (idx == sacr_pkg::DRIVER_CONFIGURATION_IDX) ||
                   (idx == sacr_pkg::IRQ_STATUS_IDX) || (idx == sacr_pkg::IRQ_MASK_IDX) ||
                   (idx == sacr_pkg::FAULT_CTRL_IDX));
  assign wr_en = i_write & ack_ff;
  assign o_waitrequest = (i_read | i_write) & ~ack_ff;
  // lanes 2 and 3 carry no register bits, so their enables are ignored
  assign wmask = {{3{i_byteenable[1]}}, {8{i_byteenable[0]}}};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // ***********************
  // configuration registers
  // ***********************
  logic [sacr_pkg::REG_W-1:0] amp_ctrl_ff;
  logic [sacr_pkg::REG_W-1:0] drv_cfg_ff;
  logic [sacr_pkg::REG_W-1:0] nxt_amp_ctrl;

  always_comb begin
    nxt_amp_ctrl = merge(amp_ctrl_ff, i_writedata, i_byteenable);
    if (wmask[sacr_pkg::AMP_INPUT_SELECT_BIT] && i_writedata[sacr_pkg::AMP_INPUT_SELECT_BIT]) begin
      nxt_amp_ctrl[sacr_pkg::LOWSIDE_OCP_REF_SELECT_BIT] = 1'b1; // R2
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      amp_ctrl_ff <= sacr_pkg::SENSE_AMP_CONTROL_RST;
    end else if (wr_en && mapped && idx == sacr_pkg::SENSE_AMP_CONTROL_IDX) begin
      amp_ctrl_ff <= nxt_amp_ctrl;
    end
  end

  // reserved bits are plain storage with no effect
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drv_cfg_ff <= sacr_pkg::DRIVER_CONFIGURATION_RST; // R11
    end else if (wr_en && mapped && idx == sacr_pkg::DRIVER_CONFIGURATION_IDX) begin
      drv_cfg_ff <= merge(drv_cfg_ff, i_writedata, i_byteenable); // R11
    end
  end

  // ***********************
  // amplifier steering outputs
  // ***********************
  assign o_amp_input_select = amp_ctrl_ff[sacr_pkg::AMP_INPUT_SELECT_BIT]; // R1
  assign o_ref_halve = amp_ctrl_ff[sacr_pkg::REF_HALVE_BIT]; // R3
  assign o_lowside_ocp_ref_select = amp_ctrl_ff[sacr_pkg::LOWSIDE_OCP_REF_SELECT_BIT]; // R4
  assign o_amp_gain_select = amp_ctrl_ff[sacr_pkg::AMP_GAIN_SELECT_LSB +: 2]; // R5
  assign o_shunt_ocp_enabled = ~amp_ctrl_ff[sacr_pkg::SHUNT_OCP_DISABLE_BIT]; // R6
  assign o_offset_cal_short = {amp_ctrl_ff[sacr_pkg::OFFSET_CAL_CHAN_A_BIT],
                               amp_ctrl_ff[sacr_pkg::OFFSET_CAL_CHAN_B_BIT],
                               amp_ctrl_ff[sacr_pkg::OFFSET_CAL_CHAN_C_BIT]}; // R7
  assign o_shunt_ocp_threshold = amp_ctrl_ff[sacr_pkg::SHUNT_OCP_THRESHOLD_LSB +: 2]; // R8
  assign o_auto_cal = drv_cfg_ff[sacr_pkg::AUTO_CAL_BIT]; // R9

  // ***********************
  // events and interrupt
  // ***********************
  logic [sacr_pkg::EVT_W-1:0] irq_stat_ff;
  logic [sacr_pkg::EVT_W-1:0] irq_mask_ff;
  logic [sacr_pkg::EVT_W-1:0] evt;
  logic [sacr_pkg::EVT_W-1:0] clr;
  logic fault_release_ff;

  // a disabled shunt fault never reaches the status register
  assign evt[sacr_pkg::EVT_SHUNT_OC] = i_shunt_overcurrent_trip & o_shunt_ocp_enabled; // R6
  assign evt[sacr_pkg::EVT_DS_OC] = i_drain_source_overcurrent_trip;
  assign clr = (wr_en && mapped && idx == sacr_pkg::IRQ_STATUS_IDX && i_byteenable[0]) ?
               i_writedata[sacr_pkg::EVT_W-1:0] : '0;

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~clr) | evt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_mask_ff <= '0;
    end else if (wr_en && mapped && idx == sacr_pkg::IRQ_MASK_IDX && i_byteenable[0]) begin
      irq_mask_ff <= i_writedata[sacr_pkg::EVT_W-1:0];
    end
  end

  // bit 0 lets software force the fault pin released for board test
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_release_ff <= 1'b0;
    end else if (wr_en && mapped && idx == sacr_pkg::FAULT_CTRL_IDX && i_byteenable[0]) begin
      fault_release_ff <= i_writedata[0];
    end
  end

  // a level, not a pulse: it drops as soon as software clears or masks the cause
  assign o_irq = |(irq_stat_ff & irq_mask_ff);

  logic fault_pull_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_pull_ff <= 1'b0;
    end else begin
      fault_pull_ff <= (|irq_stat_ff) & ~fault_release_ff;
    end
  end

  // open drain: data is always low, enable (active low) pulls the line
  assign o_fault_out_n_o = 1'b0; // R10
  assign o_fault_out_n_oe_n = ~fault_pull_ff; // R10

  // ***********************
  // read data
  // ***********************
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;
  logic [1:0] resp_ff;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (idx == sacr_pkg::SENSE_AMP_CONTROL_IDX) begin
      nxt_rdata[sacr_pkg::REG_W-1:0] = amp_ctrl_ff;
    end else if (idx == sacr_pkg::DRIVER_CONFIGURATION_IDX) begin
      nxt_rdata[sacr_pkg::REG_W-1:0] = drv_cfg_ff;
    end else if (idx == sacr_pkg::IRQ_STATUS_IDX) begin
      nxt_rdata[sacr_pkg::EVT_W-1:0] = irq_stat_ff;
    end else if (idx == sacr_pkg::IRQ_MASK_IDX) begin
      nxt_rdata[sacr_pkg::EVT_W-1:0] = irq_mask_ff;
    end else if (idx == sacr_pkg::FAULT_CTRL_IDX) begin
      nxt_rdata[0] = fault_release_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= 32'h0000_0000;
      resp_ff <= 2'h0;
    end else if (req) begin
      rdata_ff <= (i_read && mapped) ? nxt_rdata : 32'h0000_0000;
      resp_ff <= mapped ? 2'h0 : 2'h3;
    end
  end

  assign o_readdata = rdata_ff;
  assign o_response = resp_ff;

  // ***********************
  // assertions
  // ***********************
  a_fetsel_forces_ref: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
    (wr_en && mapped && idx == sacr_pkg::SENSE_AMP_CONTROL_IDX && i_byteenable[1] && i_writedata[10])
    |=> o_lowside_ocp_ref_select && o_amp_input_select)
    else $error("input select write did not force low-side reference");
  a_amp_input_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R1
    (wr_en && mapped && idx == sacr_pkg::SENSE_AMP_CONTROL_IDX && i_byteenable[1])
    |=> o_amp_input_select == $past(i_writedata[10]))
    else $error("input select not written");
  a_lsref_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
    !(wr_en && idx == sacr_pkg::SENSE_AMP_CONTROL_IDX) |=> $stable(o_lowside_ocp_ref_select))
    else $error("low-side reference changed without write");
  a_gain_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R5
    (wr_en && mapped && idx == sacr_pkg::SENSE_AMP_CONTROL_IDX && i_byteenable[0])
    |=> o_amp_gain_select == $past(i_writedata[7:6]) && o_shunt_ocp_threshold == $past(i_writedata[1:0]))
    else $error("gain or threshold not written");
  a_refhalf_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
    (wr_en && mapped && idx == sacr_pkg::SENSE_AMP_CONTROL_IDX && i_byteenable[1])
    |=> o_ref_halve == $past(i_writedata[9]))
    else $error("reference halving not written");
  a_sen_disable_blocks: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R6
    (!o_shunt_ocp_enabled && !irq_stat_ff[0] && !clr[0]) |=> !irq_stat_ff[0])
    else $error("disabled shunt fault was flagged");
  a_cal_short_map: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R7
    (wr_en && mapped && idx == sacr_pkg::SENSE_AMP_CONTROL_IDX && i_byteenable[0])
    |=> o_offset_cal_short == $past(i_writedata[4:2]))
    else $error("calibration short bits misplaced");
  a_auto_cal_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
    (wr_en && mapped && idx == sacr_pkg::DRIVER_CONFIGURATION_IDX && i_byteenable[0])
    |=> o_auto_cal == $past(i_writedata[0]))
    else $error("calibration mode not written");
  a_fault_open_drain: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
    (|irq_stat_ff && !fault_release_ff) |=> !o_fault_out_n_oe_n && !o_fault_out_n_o)
    else $error("fault pin not pulled low");
  a_rsvd_no_effect: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
    (wr_en && idx == sacr_pkg::DRIVER_CONFIGURATION_IDX) |=> $stable(amp_ctrl_ff))
    else $error("reserved write disturbed control");

  // event register: a set always beats a clear landing in the same cycle
  a_status_set_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R6
    evt[sacr_pkg::EVT_SHUNT_OC] |=> irq_stat_ff[sacr_pkg::EVT_SHUNT_OC])
    else $error("shunt event lost against a clear");
  a_status_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R6
    (irq_stat_ff[sacr_pkg::EVT_SHUNT_OC] && !clr[sacr_pkg::EVT_SHUNT_OC]) |=> irq_stat_ff[sacr_pkg::EVT_SHUNT_OC])
    else $error("shunt status dropped without a clear");
  a_ds_event_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
    i_drain_source_overcurrent_trip |=> irq_stat_ff[sacr_pkg::EVT_DS_OC])
    else $error("drain-source event not recorded");
  a_status_clear_one: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
    (clr[sacr_pkg::EVT_DS_OC] && !evt[sacr_pkg::EVT_DS_OC]) |=> !irq_stat_ff[sacr_pkg::EVT_DS_OC])
    else $error("drain-source status not cleared");

  // bus decode and byte lanes
  a_unmapped_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
    (wr_en && !mapped) |=> $stable(amp_ctrl_ff) && $stable(drv_cfg_ff) && $stable(irq_mask_ff))
    else $error("unmapped write changed a register");
  a_lane_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
    (wr_en && mapped && idx == sacr_pkg::SENSE_AMP_CONTROL_IDX && !i_byteenable[1])
    |=> $stable(o_amp_input_select) && $stable(o_ref_halve) && $stable(o_lowside_ocp_ref_select))
    else $error("upper lane changed with its byte enable low");
  a_decode_error: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
    (req && !mapped) |=> (o_response == 2'h3) && (o_readdata == 32'h0000_0000))
    else $error("unmapped access not answered with a decode error");

  // read path: data is captured in the first cycle of the request
  a_ctrl_read_data: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R1
    (req && i_read && mapped && idx == sacr_pkg::SENSE_AMP_CONTROL_IDX)
    |=> o_readdata == {21'h00_0000, $past(amp_ctrl_ff)})
    else $error("control register read back wrong");
  a_cfg_read_data: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
    (req && i_read && mapped && idx == sacr_pkg::DRIVER_CONFIGURATION_IDX)
    |=> o_readdata == {21'h00_0000, $past(drv_cfg_ff)})
    else $error("driver configuration read back wrong");

  // fault pin: released when nothing is pending or when software overrides
  a_fault_released: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
    fault_release_ff |=> o_fault_out_n_oe_n)
    else $error("fault pin pulled while released");
  a_fault_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
    !(|irq_stat_ff) |=> o_fault_out_n_oe_n)
    else $error("fault pin pulled with no status set");

  // ***********************
  // coverage
  // ***********************
  c_fet_write: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_amp_input_select && o_lowside_ocp_ref_select);
  c_irq_raise: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_irq));
  c_unmapped: cover property (@(posedge i_clk) disable iff (!i_rst_n) req && !mapped);
  c_set_clear_collide: cover property (@(posedge i_clk) disable iff (!i_rst_n) |(evt & clr));
  c_partial_lane: cover property (@(posedge i_clk) disable iff (!i_rst_n) wr_en && (i_byteenable != 4'hf));
endmodule // sacr_regs

// >>> verif/sacr_regs_test.sv
// self-checking bench for the sense amplifier configuration register bank
// assumes one 100 MHz clock, avalon-mm access and synchronous trip inputs
`timescale 1ns/100ps
module sacr_regs_test;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [4:0] i_address = 5'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0000_0000;
  logic [3:0] i_byteenable = 4'hf;
  logic i_shunt_overcurrent_trip = 1'b0;
  logic i_drain_source_overcurrent_trip = 1'b0;
  logic [31:0] o_readdata;
  logic [1:0] o_response, o_amp_gain_select, o_shunt_ocp_threshold;
  logic [2:0] o_offset_cal_short;
  logic o_waitrequest, o_amp_input_select, o_ref_halve, o_lowside_ocp_ref_select, o_shunt_ocp_enabled;
  logic o_auto_cal, o_fault_out_n_o, o_fault_out_n_oe_n, o_irq;
  logic [11:0] seen_cfg;
  logic [33:0] q[$];
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;

  sacr_regs dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_response(o_response), .i_shunt_overcurrent_trip(i_shunt_overcurrent_trip),
    .i_drain_source_overcurrent_trip(i_drain_source_overcurrent_trip), .o_amp_input_select(o_amp_input_select),
    .o_ref_halve(o_ref_halve), .o_lowside_ocp_ref_select(o_lowside_ocp_ref_select),
    .o_amp_gain_select(o_amp_gain_select), .o_shunt_ocp_enabled(o_shunt_ocp_enabled),
    .o_shunt_ocp_threshold(o_shunt_ocp_threshold), .o_offset_cal_short(o_offset_cal_short),
    .o_auto_cal(o_auto_cal), .o_fault_out_n_o(o_fault_out_n_o), .o_fault_out_n_oe_n(o_fault_out_n_oe_n),
    .o_irq(o_irq));

  assign seen_cfg = {o_amp_input_select, o_ref_halve, o_lowside_ocp_ref_select, o_amp_gain_select,
    o_shunt_ocp_enabled, o_shunt_ocp_threshold, o_offset_cal_short, o_auto_cal};

  always #5 i_clk = ~i_clk;

  // ***********************
  // checking and reporting
  // ***********************
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // expected pin view of both registers; enable is the inverse of the disable bit
  function automatic logic [11:0] cfg(input logic [10:0] c, input logic d0);
    return {c[10], c[9], c[8], c[7:6], ~c[5], c[1:0], c[4:2], d0};
  endfunction

  // read completions are taken at the edge where waitrequest is seen low
  always @(posedge i_clk) begin
    if (i_read === 1'b1 && o_waitrequest === 1'b0) begin
      if (q.size() == 0) chk({o_response, o_readdata}, 34'h0);
      else chk({o_response, o_readdata}, q.pop_front());
    end
  end

  // a hang ends the run with a mismatch; the whole sequence needs well under 1000 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ***********************
  // bus and event drivers
  // ***********************
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    i_address <= a;
    i_write <= wr;
    i_read <= ~wr;
    i_writedata <= d;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    i_write <= 1'b0;
    i_read <= 1'b0;
    // one idle edge so a following request never lands in the release time step
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [33:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task automatic trip(input logic shunt);
    if (shunt) i_shunt_overcurrent_trip <= 1'b1;
    else i_drain_source_overcurrent_trip <= 1'b1;
    @(posedge i_clk);
    i_shunt_overcurrent_trip <= 1'b0;
    i_drain_source_overcurrent_trip <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask

  // ***********************
  // main sequence
  // ***********************
  initial begin
    logic [31:0] r;
    logic [10:0] v;
    logic dv;
    dv = 1'b0;
    void'($urandom(32'h62a8));
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    chk(seen_cfg, cfg(11'h283, 1'b0));
    chk({o_fault_out_n_o, o_fault_out_n_oe_n, o_irq}, 3'b010);
    rd(5'h18, 34'h0_0000_0283);
    rd(5'h1c, 34'h0_0000_0000);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      v = 11'(i * 65);
      bus(1'b1, 5'h18, {21'h0, v});
      chk(seen_cfg, cfg(v, 1'b0));
      rd(5'h18, {23'h0, v});
    end
    $display("test gain and threshold codes done");
    for (int i = 0; i < 8; i++) begin
      r = $urandom();
      bus(1'b1, 5'h1c, r);
      dv = r[0];
      rd(5'h1c, {23'h0, r[10:0]});
      r = $urandom();
      v = r[10:0] | (r[10] ? 11'h100 : 11'h000);
      bus(1'b1, 5'h18, r);
      chk(seen_cfg, cfg(v, dv));
      rd(5'h18, {23'h0, v});
    end
    bus(1'b1, 5'h18, 32'h0000_0400);
    rd(5'h18, 34'h0_0000_0500);
    bus(1'b1, 5'h18, 32'h0000_0000);
    rd(5'h18, 34'h0_0000_0000);
    i_byteenable <= 4'h1;
    bus(1'b1, 5'h18, 32'h0000_07fe);
    rd(5'h18, 34'h0_0000_00fe);
    i_byteenable <= 4'h2;
    bus(1'b1, 5'h18, 32'h0000_0400);
    rd(5'h18, 34'h0_0000_05fe);
    i_byteenable <= 4'hf;
    bus(1'b1, 5'h18, 32'h0000_0000);
    $display("test random access done");
    rd(5'h00, 34'h3_0000_0000);
    bus(1'b1, 5'h00, 32'hffff_ffff);
    rd(5'h19, 34'h3_0000_0000);
    rd(5'h18, 34'h0_0000_0000);
    $display("test unmapped access done");
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    chk(seen_cfg, cfg(11'h283, 1'b0));
    rd(5'h1c, 34'h0_0000_0000);
    $display("test mid-run reset done");
    bus(1'b1, 5'h0c, 32'h0000_0000);
    trip(1'b1);
    chk({o_irq, o_fault_out_n_oe_n, o_fault_out_n_o}, 3'b000);
    rd(5'h08, 34'h0_0000_0001);
    bus(1'b1, 5'h0c, 32'h0000_0001);
    chk(o_irq, 1'b1);
    bus(1'b1, 5'h08, 32'h0000_0001);
    // the pin follows the status one edge later than the interrupt
    @(posedge i_clk);
    chk({o_irq, o_fault_out_n_oe_n}, 2'b01);
    trip(1'b0);
    rd(5'h08, 34'h0_0000_0002);
    bus(1'b1, 5'h0c, 32'h0000_0003);
    chk({o_irq, o_fault_out_n_oe_n}, 2'b10);
    bus(1'b1, 5'h10, 32'h0000_0001);
    @(posedge i_clk);
    chk({o_irq, o_fault_out_n_oe_n}, 2'b11);
    bus(1'b1, 5'h10, 32'h0000_0000);
    bus(1'b1, 5'h08, 32'h0000_0002);
    // a clear landing while the trip is still high must lose
    i_shunt_overcurrent_trip <= 1'b1;
    bus(1'b1, 5'h08, 32'h0000_0001);
    i_shunt_overcurrent_trip <= 1'b0;
    rd(5'h08, 34'h0_0000_0001);
    bus(1'b1, 5'h08, 32'h0000_0001);
    bus(1'b1, 5'h18, 32'h0000_0020);
    trip(1'b1);
    rd(5'h08, 34'h0_0000_0000);
    chk({o_irq, o_fault_out_n_oe_n}, 2'b01);
    $display("test interrupt and fault pin done");
    report_and_stop();
  end
endmodule // sacr_regs_test
